// >>> core/rfb_pkg.sv
package rfb_pkg;

    // Register addresses as seen in the first byte of an SPI frame.
    localparam logic [6:0] RFB_ADDR_CTRL2 = 7'h08;
    localparam logic [6:0] RFB_ADDR_AFULL = 7'h7e;
    localparam logic [6:0] RFB_ADDR_PORT = 7'h7f;

    // Power-on values of the writable registers.
    localparam logic [7:0] RFB_CTRL2_RST = 8'h00;
    localparam logic [7:0] RFB_AFULL_RST = 8'h37;

    // Width of the almost-full level field, bits 5..0 of its register.
    localparam int RFB_AFTHR_W = 6;

    // SPI frame layout: first byte is direction bit then 7 address bits.
    localparam int RFB_SPI_BITS = 8;
    localparam int RFB_SPI_WR_BIT = 7;

    // Receive buffer geometry and byte width.
    localparam int RFB_FIFO_DEPTH = 64;
    localparam int RFB_BYTE_W = 8;

    // Frame detection defaults: preamble run, sync word and its timeout.
    localparam int RFB_PRE_BITS = 16;
    localparam int RFB_SYNC_W = 16;
    localparam logic [15:0] RFB_SYNC_WORD = 16'h2dd4;
    localparam int RFB_SYNC_TMO_BITS = RFB_SYNC_W + 4;

    // Index of each pin in the synchroniser bank.
    localparam int RFB_PIN_SEL = 0;
    localparam int RFB_PIN_SCLK = 1;
    localparam int RFB_PIN_SDI = 2;
    localparam int RFB_PIN_N = 3;
    localparam logic [2:0] RFB_PIN_RST = 3'h1;

    // Field layout of the second operating and function control register.
    typedef struct packed {
        logic [2:0] antdiv;
        logic multi_pkt;
        logic rsvd3;
        logic low_duty;
        logic buf_clear;
        logic rsvd0;
    } rfb_ctrl2_t;

    // Receive framing states, Gray coded along hunt, sync, store.
    typedef enum logic [1:0] {
        RFB_HUNT_PRE = 2'b00,
        RFB_HUNT_SYNC = 2'b01,
        RFB_STORE = 2'b11
    } rfb_rx_state_t;

endpackage

// >>> core/rfb_rx_buffer.sv
`timescale 1ns/1ps

// Byte FIFO with flip-flop storage; DEPTH must be a power of two.
module rfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshake terms; a full buffer refuses and an empty one offers nothing.
    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    assign level = count_reg;

    // Storage needs no reset; pointers decide what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count; flush drops everything at once.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // rfb_fifo

// Overview of operation
// - Buffer 64 received bytes only while receiving.
// - Burst read at 7Fh returns successive bytes.
// - Almost-full level 6 bits, reset 37h.
// - Crossing almost-full level raises active-low interrupt.
// - Clear bit in register 08 empties buffer.
// - Disabled source still sets readable status.
// - Packet handling only with buffered receive.
// - Preamble is alternating bits starting with zero.
// - Store only after preamble and sync found.
// - Raw mode stores every post-sync bit unchecked.
// - Raw mode: Manchester yes, no whitening/CRC.
// - Valid packet clears receive unless multi-packet set.
// - Leave receive state on packet-valid event unless multi-packet set.
module rfb_rx_buffer #(
    parameter int DEPTH = rfb_pkg::RFB_FIFO_DEPTH,
    parameter int PRE_BITS = rfb_pkg::RFB_PRE_BITS,
    parameter logic [15:0] SYNC_WORD = rfb_pkg::RFB_SYNC_WORD
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic spi_sel_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic demod_bit,
    input wire logic demod_valid,
    input wire logic man_en,
    input wire logic pkt_en,
    input wire logic rx_on_set,
    input wire logic pkt_valid_evt,
    input wire logic afull_irq_en,
    input wire logic afull_status_clr,
    output logic irq_n,
    output logic afull_status,
    output logic rx_on,
    output logic pkt_handling_active,
    output logic rx_overflow,
    output rfb_pkg::rfb_ctrl2_t ctrl2
);
    import rfb_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [RFB_PIN_N-1:0] pin_s1_reg;
    logic [RFB_PIN_N-1:0] pin_s2_reg;
    logic [RFB_PIN_N-1:0] pin_s3_reg;
    logic [RFB_PIN_N-1:0] pin_f_reg;
    logic sclk_prev_reg;
    logic sel_f;
    logic sclk_rise;
    logic [6:0] sh_in_reg;
    logic [2:0] bit_cnt_reg;
    logic in_data_reg;
    logic is_write_reg;
    logic [6:0] addr_reg;
    logic [7:0] tx_reg;
    logic [7:0] spi_byte;
    logic byte_end;
    logic rd_load;
    logic [6:0] rd_addr;
    logic [7:0] rd_val;
    logic wr_strobe;
    rfb_ctrl2_t ctrl2_reg;
    logic [RFB_AFTHR_W-1:0] afthr_reg;
    logic sdo_reg;
    logic sdo_oe_n_reg;
    logic rx_on_reg;
    rfb_rx_state_t rx_state_reg;
    logic last_bit_reg;
    logic [7:0] run_reg;
    logic [15:0] sync_sh_reg;
    logic [7:0] tmo_reg;
    logic chip_half_reg;
    logic chip_first_reg;
    logic data_valid;
    logic data_bit;
    logic [7:0] asm_reg;
    logic [2:0] asm_cnt_reg;
    logic pend_reg;
    logic [7:0] pend_data_reg;
    logic overflow_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [AW:0] fifo_level;
    logic above_reg;
    logic status_reg;
    logic irq_n_reg;
    logic pkt_act_reg;
    logic flush;
    logic pop_due_reg;

    // Three-stage synchronisers; a pin change is taken once stages 2 and 3
    // agree, which filters a single-sample glitch.
    for (genvar i = 0; i < RFB_PIN_N; i++) begin : g_pin
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                pin_s1_reg[i] <= RFB_PIN_RST[i];
                pin_s2_reg[i] <= RFB_PIN_RST[i];
                pin_s3_reg[i] <= RFB_PIN_RST[i];
                pin_f_reg[i] <= RFB_PIN_RST[i];
            end else begin
                pin_s1_reg[i] <= (i == RFB_PIN_SEL) ? spi_sel_n :
                                 (i == RFB_PIN_SCLK) ? spi_sclk : spi_sdi;
                pin_s2_reg[i] <= pin_s1_reg[i];
                pin_s3_reg[i] <= pin_s2_reg[i];
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_f_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    // Edge finding on the filtered serial clock.
    assign sel_f = pin_f_reg[RFB_PIN_SEL];
    assign sclk_rise = !sel_f & pin_f_reg[RFB_PIN_SCLK] & !sclk_prev_reg;
    assign byte_end = sclk_rise & (bit_cnt_reg == 3'(RFB_SPI_BITS - 1));
    assign spi_byte = {sh_in_reg, pin_f_reg[RFB_PIN_SDI]};
    assign wr_strobe = byte_end & in_data_reg & is_write_reg;
    assign rd_load = byte_end & (in_data_reg ? !is_write_reg :
                                 !spi_byte[RFB_SPI_WR_BIT]);
    // The buffer port keeps its address in a burst; others step forward.
    assign rd_addr = !in_data_reg ? spi_byte[6:0] :
                     (addr_reg == RFB_ADDR_PORT) ? addr_reg :
                     addr_reg + 7'h01;

    // Read mux; reserved bits and unmapped addresses read as zero.
    always_comb begin
        rd_val = 8'h00;
        case (rd_addr)
            RFB_ADDR_CTRL2: rd_val = ctrl2_reg;
            RFB_ADDR_AFULL: rd_val = {2'b00, afthr_reg};
            RFB_ADDR_PORT: rd_val = fifo_out_valid ? fifo_out_data : 8'h00;
            default: rd_val = 8'h00;
        endcase
    end

    // SPI frame tracking: header byte, then data bytes until deselect.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_reg <= 1'b0;
            sh_in_reg <= 7'h00;
            bit_cnt_reg <= 3'h0;
            in_data_reg <= 1'b0;
            is_write_reg <= 1'b0;
            addr_reg <= 7'h00;
        end else begin
            sclk_prev_reg <= pin_f_reg[RFB_PIN_SCLK];
            if (sel_f) begin
                bit_cnt_reg <= 3'h0;
                in_data_reg <= 1'b0;
            end else if (sclk_rise) begin
                sh_in_reg <= spi_byte[6:0];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (byte_end && !in_data_reg) begin
                    in_data_reg <= 1'b1;
                    is_write_reg <= spi_byte[RFB_SPI_WR_BIT];
                    addr_reg <= spi_byte[6:0];
                end else if (byte_end) begin
                    addr_reg <= (addr_reg == RFB_ADDR_PORT) ? addr_reg :
                                addr_reg + 7'h01;
                end
            end
        end
    end

    // Outgoing shifter; data moves just after each rising edge so the host
    // sees it settled well before the next one.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_reg <= 8'h00;
            sdo_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1;
        end else begin
            sdo_oe_n_reg <= sel_f;
            if (rd_load) begin
                tx_reg <= rd_val;
                sdo_reg <= rd_val[7];
            end else if (sclk_rise) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sdo_reg <= tx_reg[6];
            end
        end
    end

    // Writable registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl2_reg <= rfb_ctrl2_t'(RFB_CTRL2_RST);
            afthr_reg <= RFB_AFULL_RST[RFB_AFTHR_W-1:0];
        end else if (wr_strobe) begin
            if (addr_reg == RFB_ADDR_CTRL2) begin
                ctrl2_reg <= spi_byte;
                ctrl2_reg.rsvd3 <= 1'b0;
                ctrl2_reg.rsvd0 <= 1'b0;
            end
            if (addr_reg == RFB_ADDR_AFULL) begin
                afthr_reg <= spi_byte[RFB_AFTHR_W-1:0];
            end
        end
    end

    assign flush = ctrl2_reg.buf_clear;

    // Receive-on flag; a start request wins over a same-cycle stop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_on_reg <= 1'b0;
            pkt_act_reg <= 1'b0;
        end else begin
            if (rx_on_set) begin
                rx_on_reg <= 1'b1;
            end else if (pkt_valid_evt && pkt_en && !ctrl2_reg.multi_pkt) begin
                rx_on_reg <= 1'b0;
            end
            pkt_act_reg <= pkt_en & rx_on_reg & !flush;
        end
    end

    // Framing: hunt preamble, hunt sync with timeout, then store.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg <= RFB_HUNT_PRE;
            last_bit_reg <= 1'b0;
            run_reg <= 8'h00;
            sync_sh_reg <= 16'h0000;
            tmo_reg <= 8'h00;
        end else if (!rx_on_reg || flush) begin
            rx_state_reg <= RFB_HUNT_PRE;
            run_reg <= 8'h00;
            tmo_reg <= 8'h00;
        end else if (demod_valid) begin
            last_bit_reg <= demod_bit;
            sync_sh_reg <= {sync_sh_reg[14:0], demod_bit};
            case (rx_state_reg)
                RFB_HUNT_PRE: begin
                    if (run_reg != 8'h00 && demod_bit != last_bit_reg) begin
                        run_reg <= run_reg + 8'h01;
                    end else begin
                        run_reg <= demod_bit ? 8'h00 : 8'h01;
                    end
                    if (run_reg >= 8'(PRE_BITS)) begin
                        rx_state_reg <= RFB_HUNT_SYNC;
                        tmo_reg <= 8'h00;
                    end
                end
                RFB_HUNT_SYNC: begin
                    if ({sync_sh_reg[14:0], demod_bit} == SYNC_WORD) begin
                        rx_state_reg <= RFB_STORE;
                    end else if (tmo_reg >= 8'(RFB_SYNC_TMO_BITS)) begin
                        rx_state_reg <= RFB_HUNT_PRE;
                        run_reg <= 8'h00;
                    end
                    // Timeout counts only once the preamble pattern stops.
                    if (demod_bit != last_bit_reg && tmo_reg == 8'h00) begin
                        tmo_reg <= 8'h00;
                    end else begin
                        tmo_reg <= tmo_reg + 8'h01;
                    end
                end
                RFB_STORE: rx_state_reg <= RFB_STORE;
                default: rx_state_reg <= RFB_HUNT_PRE;
            endcase
        end
    end

    // Manchester pairs only.
    // Chip pair 10 gives a one and 01 gives a zero; no de-whitening and no
    // CRC or header check happen here.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_half_reg <= 1'b0;
            chip_first_reg <= 1'b0;
        end else if (rx_state_reg != RFB_STORE || !man_en) begin
            chip_half_reg <= 1'b0;
        end else if (demod_valid) begin
            chip_half_reg <= !chip_half_reg;
            chip_first_reg <= demod_bit;
        end
    end

    assign data_valid = demod_valid & (rx_state_reg == RFB_STORE) &
                        (!man_en | chip_half_reg);
    assign data_bit = man_en ? chip_first_reg : demod_bit;

    // Raw bits to bytes.
    // One byte may wait for room; a second finished meanwhile is lost and
    // flagged, since the modem stream cannot be paused.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            asm_reg <= 8'h00;
            asm_cnt_reg <= 3'h0;
            pend_reg <= 1'b0;
            pend_data_reg <= 8'h00;
            overflow_reg <= 1'b0;
        end else if (flush || rx_state_reg != RFB_STORE) begin
            asm_cnt_reg <= 3'h0;
            pend_reg <= pend_reg & !flush;
            overflow_reg <= overflow_reg & !flush;
        end else begin
            if (pend_reg && fifo_in_ready) begin
                pend_reg <= 1'b0;
            end
            if (data_valid) begin
                asm_reg <= {asm_reg[6:0], data_bit};
                asm_cnt_reg <= asm_cnt_reg + 3'h1;
                if (asm_cnt_reg == 3'h7) begin
                    if (pend_reg && !fifo_in_ready) begin
                        overflow_reg <= 1'b1;
                    end else begin
                        pend_reg <= 1'b1;
                        pend_data_reg <= {asm_reg[6:0], data_bit};
                    end
                end
            end
        end
    end

    // Pop once shifted.
    // The pop waits for the next rise, so a burst's end loses no byte.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pop_due_reg <= 1'b0;
        end else if (rd_load && rd_addr == RFB_ADDR_PORT) begin
            pop_due_reg <= fifo_out_valid;
        end else if (sel_f || sclk_rise || flush) begin
            pop_due_reg <= 1'b0;
        end
    end

    rfb_fifo #(
        .WIDTH(RFB_BYTE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(flush),
        .in_valid(pend_reg & rx_on_reg),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(pop_due_reg & sclk_rise),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // Status despite mask.
    // A crossing in the same cycle as a clear keeps the status set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            above_reg <= 1'b0;
            status_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            above_reg <= (fifo_level > (AW+1)'(afthr_reg));
            if ((fifo_level > (AW+1)'(afthr_reg)) && !above_reg) begin
                status_reg <= 1'b1;
            end else if (afull_status_clr) begin
                status_reg <= 1'b0;
            end
            irq_n_reg <= !(status_reg & afull_irq_en);
        end
    end

    assign spi_sdo = sdo_reg;
    assign spi_sdo_oe_n = sdo_oe_n_reg;
    assign irq_n = irq_n_reg;
    assign afull_status = status_reg;
    assign rx_on = rx_on_reg;
    assign pkt_handling_active = pkt_act_reg;
    assign rx_overflow = overflow_reg;
    assign ctrl2 = ctrl2_reg;
endmodule // rfb_rx_buffer

// >>> testbench/rfb_rx_buffer_assertions.sv
`timescale 1ns/1ps

// Port-level checker for the receive buffer; it sees only the top ports.
module rfb_rx_buffer_chk (
    input logic clk,
    input logic reset_n,
    input logic spi_sel_n,
    input logic spi_sclk,
    input logic spi_sdi,
    input logic spi_sdo,
    input logic spi_sdo_oe_n,
    input logic demod_bit,
    input logic demod_valid,
    input logic man_en,
    input logic pkt_en,
    input logic rx_on_set,
    input logic pkt_valid_evt,
    input logic afull_irq_en,
    input logic afull_status_clr,
    input logic irq_n,
    input logic afull_status,
    input logic rx_on,
    input logic pkt_handling_active,
    input logic rx_overflow,
    input rfb_pkg::rfb_ctrl2_t ctrl2
);
    import rfb_pkg::*;

    // Everything here lives in the system clock domain.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Interrupt pin and status behaviour.
    property p_irq_follow;
        irq_n == !($past(afull_status) && $past(afull_irq_en));
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("irq_n does not follow enabled status");
    property p_irq_masked;
        !afull_irq_en |=> irq_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked source drove irq_n low");
    property p_status_sticky;
        afull_status && !afull_status_clr |=> afull_status;
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("status dropped without a clear");

    // Serial output enable tracks the synchronised select.
    property p_oe_idle;
        spi_sel_n [*6] |-> spi_sdo_oe_n;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("sdo enabled while not selected");
    property p_oe_active;
        !spi_sel_n [*6] |-> !spi_sdo_oe_n;
    endproperty
    a_oe_active: assert property (p_oe_active)
        else $error("sdo not enabled while selected");

    // Receive-on state and the packet handler gate.
    property p_pkt_active;
        pkt_handling_active ==
            ($past(pkt_en) && $past(rx_on) && !$past(ctrl2.buf_clear));
    endproperty
    a_pkt_active: assert property (p_pkt_active)
        else $error("packet handling gate wrong");
    property p_rx_set;
        rx_on_set |=> rx_on;
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive mode not entered");
    property p_rx_rise;
        $rose(rx_on) |-> $past(rx_on_set);
    endproperty
    a_rx_rise: assert property (p_rx_rise)
        else $error("receive mode entered without request");
    property p_rx_clear;
        rx_on && pkt_valid_evt && pkt_en && !ctrl2.multi_pkt && !rx_on_set
            |=> !rx_on;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("receive mode kept after valid packet");
    property p_rx_hold;
        rx_on && !(pkt_valid_evt && pkt_en && !ctrl2.multi_pkt) |=> rx_on;
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("receive mode left without cause");

    // A held clear bit also wipes the lost-byte flag.
    property p_ovf_clear;
        ctrl2.buf_clear [*3] |-> !rx_overflow;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag survives buffer clear");
endmodule // rfb_rx_buffer_chk

bind rfb_rx_buffer rfb_rx_buffer_chk rfb_rx_buffer_chk_inst (
    .clk(clk), .reset_n(reset_n), .spi_sel_n(spi_sel_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .demod_bit(demod_bit),
    .demod_valid(demod_valid), .man_en(man_en), .pkt_en(pkt_en),
    .rx_on_set(rx_on_set), .pkt_valid_evt(pkt_valid_evt),
    .afull_irq_en(afull_irq_en), .afull_status_clr(afull_status_clr),
    .irq_n(irq_n), .afull_status(afull_status), .rx_on(rx_on),
    .pkt_handling_active(pkt_handling_active),
    .rx_overflow(rx_overflow), .ctrl2(ctrl2)
);

// >>> testbench/rfb_host_model.sv
`timescale 1ns/1ps

// Host microcontroller on the SPI pins; sclk rests low between frames.
module rfb_host_model (
    input logic clk,
    output logic spi_sel_n,
    output logic spi_sclk,
    output logic spi_sdi,
    input logic spi_sdo
);
    logic [7:0] rd_q[$];

    // Idle pins at time zero.
    initial begin
        spi_sel_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end

    // burst frame, slow clock.
    // One frame: header then n data bytes, sdo captured before each rise.
    task automatic frame(input logic [7:0] hdr, input logic [7:0] wdat,
                         input int n);
        logic [7:0] rb;
        rd_q = {};
        @(negedge clk);
        spi_sel_n = 1'b0;
        for (int b = 0; b <= n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                spi_sdi = (b == 0) ? hdr[i] : wdat[i];
                repeat (8) @(negedge clk);
                rb[i] = spi_sdo;
                spi_sclk = 1'b1;
                repeat (8) @(negedge clk);
                spi_sclk = 1'b0;
            end
            if (b > 0) rd_q.push_back(rb);
        end
        repeat (8) @(negedge clk);
        spi_sel_n = 1'b1;
        spi_sdi = ~spi_sdi; // Released line shows no stale value.
        repeat (8) @(negedge clk);
    endtask
endmodule // rfb_host_model

// >>> testbench/rx_fifo_raw_packet_intake_test.sv
`timescale 1ns/1ps

// Self-checking bench for the receive buffer with a host model.
module rx_fifo_raw_packet_intake_test;
    import rfb_pkg::*;

    logic clk, reset_n, demod_bit, demod_valid, man_en, pkt_en;
    logic rx_on_set, pkt_valid_evt, afull_irq_en, afull_status_clr;
    logic spi_sel_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n, irq_n;
    logic afull_status, rx_on, pkt_handling_active, rx_overflow;
    rfb_ctrl2_t ctrl2;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int comparisons = 0;

    rfb_rx_buffer rfb_rx_buffer_inst (
        .clk(clk), .reset_n(reset_n), .spi_sel_n(spi_sel_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n), .demod_bit(demod_bit),
        .demod_valid(demod_valid), .man_en(man_en), .pkt_en(pkt_en),
        .rx_on_set(rx_on_set), .pkt_valid_evt(pkt_valid_evt),
        .afull_irq_en(afull_irq_en), .afull_status_clr(afull_status_clr),
        .irq_n(irq_n), .afull_status(afull_status), .rx_on(rx_on),
        .pkt_handling_active(pkt_handling_active),
        .rx_overflow(rx_overflow), .ctrl2(ctrl2)
    );
    rfb_host_model rfb_host_model_inst (
        .clk(clk), .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo)
    );

    // 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Status and pin expected after n bytes against a threshold.
    function automatic logic [7:0] flags(int n, int thr, logic en);
        return {6'h00, n > thr, !(n > thr && en)};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rfb_host_model_inst.frame({1'b1, a}, d, 1);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        rfb_host_model_inst.frame({1'b0, a}, 8'h00, 1);
        chk(rfb_host_model_inst.rd_q[0], e);
    endtask

    // Reads n bytes in one burst; an empty buffer answers zero.
    task automatic drain(input int n);
        rfb_host_model_inst.frame({1'b0, RFB_ADDR_PORT}, 8'h00, n);
        for (int k = 0; k < n; k++)
            chk(rfb_host_model_inst.rd_q[k],
                exp_q.size() ? exp_q.pop_front() : 8'h00);
    endtask

    task automatic send_bit(input logic b);
        demod_bit = b;
        demod_valid = 1'b1;
        @(negedge clk);
        demod_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Preamble, sync, n random bytes, then a valid packet ends receive.
    task automatic rx_frame(input logic [15:0] pre, input int n);
        logic [7:0] d;
        pulse(rx_on_set);
        for (int i = 15; i >= 0; i--) send_bit(pre[i]);
        for (int i = 15; i >= 0; i--) send_bit(RFB_SYNC_WORD[i]);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            if (pre == 16'h5555 && k < RFB_FIFO_DEPTH) exp_q.push_back(d);
            for (int i = 7; i >= 0; i--) begin
                send_bit(d[i]);
                if (man_en) send_bit(!d[i]);
            end
        end
        pkt_en = 1'b1;
        pulse(pkt_valid_evt);
        pkt_en = 1'b0;
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog against a hang.
    initial begin
        #800000;
        n_errors++;
        close_out();
    end

    // Main sequence.
    initial begin
        {reset_n, demod_bit, demod_valid, man_en, pkt_en} = 5'h00;
        {rx_on_set, pkt_valid_evt, afull_irq_en, afull_status_clr} = 4'h0;
        void'($urandom(81361));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        rd(RFB_ADDR_CTRL2, RFB_CTRL2_RST);
        rd(RFB_ADDR_AFULL, RFB_AFULL_RST);
        rd(7'h10, 8'h00);
        wr(RFB_ADDR_AFULL, 8'hc3);
        rd(RFB_ADDR_AFULL, 8'h03);
        wr(RFB_ADDR_PORT, 8'h5a);
        drain(1);
        $display("test registers done");
        afull_irq_en = 1'b1;
        rx_frame(16'h5555, 4);
        chk({6'h00, afull_status, irq_n}, flags(4, 3, 1'b1));
        drain(4);
        pulse(afull_status_clr);
        afull_irq_en = 1'b0;
        rx_frame(16'h5555, 5);
        chk({6'h00, afull_status, irq_n}, flags(5, 3, 1'b0));
        drain(2);
        drain(1);
        $display("test interrupt done");
        wr(RFB_ADDR_CTRL2, 8'h02);
        exp_q.delete();
        drain(1);
        pkt_en = 1'b1;
        pulse(rx_on_set);
        chk({7'h00, pkt_handling_active}, 8'h00);
        wr(RFB_ADDR_CTRL2, 8'h10);
        chk(ctrl2, 8'h10);
        chk({7'h00, pkt_handling_active}, 8'h01);
        pulse(pkt_valid_evt);
        chk({7'h00, rx_on}, 8'h01);
        wr(RFB_ADDR_CTRL2, 8'h00);
        pulse(pkt_valid_evt);
        chk({7'h00, rx_on}, 8'h00);
        pkt_en = 1'b0;
        $display("test clear and mode done");
        rx_frame(16'haaaa, 2);
        exp_q.delete();
        drain(1);
        man_en = 1'b1;
        rx_frame(16'h5555, 2);
        man_en = 1'b0;
        drain(2);
        $display("test preamble and coding done");
        rx_frame(16'h5555, RFB_FIFO_DEPTH + 2);
        chk({7'h00, rx_overflow}, 8'h01);
        drain(RFB_FIFO_DEPTH + 1);
        pulse(afull_status_clr);
        chk({7'h00, afull_status}, 8'h00);
        wr(RFB_ADDR_CTRL2, 8'h02);
        chk({7'h00, rx_overflow}, 8'h00);
        $display("test overflow done");
        close_out();
    end
endmodule // rx_fifo_raw_packet_intake_test
